// ### rtl/fan_pkg.sv
// constants, register map and rate table of the fan acoustic configuration block
package fan_pkg;
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned DUTY_FULL      = 255;
	// full-scale ramp time at rate code 000, in tenths of a second
	localparam int unsigned RAMP_FAST_DSEC = 375;
	localparam int unsigned RAMP_SLOW_DSEC = 522;
	localparam int unsigned SLOT_FAST_CYC  = int'((64'(RAMP_FAST_DSEC) * 64'(CLK_HZ))
		/ (64'(10) * 64'(DUTY_FULL)));
	localparam int unsigned SLOT_SLOW_CYC  = int'((64'(RAMP_SLOW_DSEC) * 64'(CLK_HZ))
		/ (64'(10) * 64'(DUTY_FULL)));
	localparam logic [7:0]  PWM_LAST       = 8'hFE;

	// register indices; byte address is four times the index
	localparam logic [7:0]  IDX_CFG6       = 8'h10;
	localparam logic [7:0]  IDX_CFG1       = 8'h40;
	localparam logic [7:0]  IDX_FAN_CFG    = 8'h62;
	localparam logic [7:0]  IDX_ACOU2      = 8'h63;
	localparam logic [7:0]  IDX_DUTY_STAT  = 8'h70;

	localparam int unsigned CFG6_SLOW_BIT  = 7;
	localparam int unsigned CFG1_LOCK_BIT  = 1;
	localparam int unsigned FC_SMOOTH_BIT  = 3;
	localparam int unsigned FC_SYNC_BIT    = 4;
	localparam int unsigned FC_MINSEL_LSB  = 5;
	localparam int unsigned ACOU_RATE_LSB  = 0;

	localparam logic [7:0]  CFG6_RST       = 8'h00;
	localparam logic [7:0]  CFG1_RST       = 8'h00;
	localparam logic [7:0]  FAN_CFG_RST    = 8'h00;
	localparam logic [7:0]  ACOU2_RST      = 8'h00;

	localparam logic [1:0]  SRC_LOCAL      = 2'h0;
	localparam logic [1:0]  SRC_REMOTE1    = 2'h1;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// duty increase per time slot for each rate code
	function automatic logic [7:0] rate_step(input logic [2:0] code);
		case (code)
			3'h0:    rate_step = 8'h01;
			3'h1:    rate_step = 8'h02;
			3'h2:    rate_step = 8'h03;
			3'h3:    rate_step = 8'h04;
			3'h4:    rate_step = 8'h08;
			3'h5:    rate_step = 8'h0C;
			3'h6:    rate_step = 8'h18;
			default: rate_step = 8'h30;
		endcase
	endfunction : rate_step
endpackage : fan_pkg

// ### rtl/ramp_if.sv
// control and result signals between the config block and one fan channel
`timescale 1ns/100ps
interface ramp_if;
	logic       slot_tick;
	logic [7:0] step;
	logic       ramp_en;
	logic [7:0] target;
	logic       auto_mode;
	logic       below;
	logic [7:0] min_duty;
	logic       min_sel;
	logic [7:0] ramp;
	logic [7:0] duty;
	logic       pwm;
	modport ctrl (output slot_tick, step, ramp_en, target, auto_mode, below, min_duty, min_sel,
		input ramp, duty, pwm);
	modport chan (input slot_tick, step, ramp_en, target, auto_mode, below, min_duty, min_sel,
		output ramp, duty, pwm);
endinterface : ramp_if

// ### rtl/fan_channel.sv
// one fan output: duty ramp, below-threshold floor and pwm waveform
`timescale 1ns/100ps
module fan_channel
	import fan_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic clk_en,
	ramp_if.chan      ch
);
	logic [7:0] ramp_ff;
	logic [7:0] nxt_ramp;
	logic [7:0] duty_ff;
	logic [7:0] nxt_duty;
	logic [7:0] pcnt_ff;
	logic [7:0] nxt_pcnt;
	logic       pwm_ff;
	logic       nxt_pwm;

	always_comb begin
		nxt_ramp = ramp_ff;
		if (!ch.ramp_en) begin
			nxt_ramp = ch.target;
		end else if (ch.slot_tick) begin
			// step toward target, never overshoot
			if (ch.target > ramp_ff) begin
				nxt_ramp = (8'(ch.target - ramp_ff) > ch.step) ? 8'(ramp_ff + ch.step) : ch.target;
			end else if (ch.target < ramp_ff) begin
				nxt_ramp = (8'(ramp_ff - ch.target) > ch.step) ? 8'(ramp_ff - ch.step) : ch.target;
			end
		end
		if (ch.auto_mode && ch.below) begin
			nxt_duty = ch.min_sel ? ch.min_duty : 8'h00;
		end else begin
			nxt_duty = ramp_ff;
		end
		nxt_pcnt = (pcnt_ff == PWM_LAST) ? 8'h00 : 8'(pcnt_ff + 8'h01);
		nxt_pwm  = (pcnt_ff < duty_ff);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ramp_ff <= 8'h00;
			duty_ff <= 8'h00;
			pcnt_ff <= 8'h00;
			pwm_ff  <= 1'b0;
		end else if (clk_en) begin
			ramp_ff <= nxt_ramp;
			duty_ff <= nxt_duty;
			pcnt_ff <= nxt_pcnt;
			pwm_ff  <= nxt_pwm;
		end
	end

	assign ch.ramp = ramp_ff;
	assign ch.duty = duty_ff;
	assign ch.pwm  = pwm_ff;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_step_up;
		clk_en && ch.ramp_en && ch.slot_tick && (ch.target > ramp_ff);
	endsequence

	a_ramp_change_bounded: assert property (
		clk_en && ch.ramp_en |=> ((ramp_ff >= $past(ramp_ff)) ? 8'(ramp_ff - $past(ramp_ff))
			: 8'($past(ramp_ff) - ramp_ff)) <= $past(ch.step))
		else $error("ramp moved more than one step");
	a_ramp_advances_up: assert property (
		s_step_up |=> (ramp_ff > $past(ramp_ff)) && (ramp_ff <= $past(ch.target)))
		else $error("ramp did not advance toward target");
endmodule : fan_channel

// ### rtl/fan_acoustic_control_config.sv
// fan acoustic configuration block: axi4-lite registers, slot timer and three fan channels
// Function
// - remote-one smoothing bit set: fan changes from remote one are ramped
// - sync bit 1 ties speed inputs b, c, d to fan c; 0 only c, d
// - auto mode below threshold: fan a drives 0% or its minimum per select bit
// - auto mode below threshold: fan b drives 0% or its minimum per select bit
// - auto mode below threshold: fan c drives 0% or its minimum per select bit
// - lock bit set: cfg1, fan config and acoustic two ignore all later writes; cfg6 still takes them
// - acoustic register two resets to zero
// - local rate field bounds how fast duty changes for local temperature
// - duty ramps toward a new value instead of jumping for local source and for remote one with smoothing on
// - slow bit 0: code 000 steps one per slot, full ramp 37.5 s
// - slow bit 1: code 000 full ramp 52.2 s; code 111 steps 48
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
module fan_acoustic_control_config
	import fan_pkg::*;
#(
	parameter int unsigned ADDR_W    = 12,
	parameter int unsigned FAST_CYC  = SLOT_FAST_CYC,
	parameter int unsigned SLOW_CYC  = SLOT_SLOW_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [2:0]        auto_mode,
	input  wire logic [2:0]        below_threshold,
	input  wire logic [2:0][7:0]   target_duty,
	input  wire logic [2:0][7:0]   min_duty,
	input  wire logic [2:0][1:0]   control_source,
	output logic                   fan_drive_a,
	output logic                   fan_drive_b,
	output logic                   fan_drive_c,
	output logic [3:0]             speed_sync_enable
);
	logic [ADDR_W-1:0] awaddr_ff;
	logic [ADDR_W-1:0] nxt_awaddr;
	logic              aw_got_ff;
	logic              nxt_aw_got;
	logic [7:0]        wdata_ff;
	logic [7:0]        nxt_wdata;
	logic              wstrb0_ff;
	logic              nxt_wstrb0;
	logic              w_got_ff;
	logic              nxt_w_got;
	logic              bvalid_ff;
	logic              nxt_bvalid;
	logic [1:0]        bresp_ff;
	logic [1:0]        nxt_bresp;
	logic              rvalid_ff;
	logic              nxt_rvalid;
	logic [31:0]       rdata_ff;
	logic [31:0]       nxt_rdata;
	logic [1:0]        rresp_ff;
	logic [1:0]        nxt_rresp;
	logic [7:0]        cfg6_ff;
	logic [7:0]        nxt_cfg6;
	logic [7:0]        cfg1_ff;
	logic [7:0]        nxt_cfg1;
	logic [7:0]        fan_cfg_ff;
	logic [7:0]        nxt_fan_cfg;
	logic [7:0]        acou2_ff;
	logic [7:0]        nxt_acou2;
	logic [3:0]        sync_ff;
	logic [3:0]        nxt_sync;
	logic [31:0]       slot_cnt_ff;
	logic [31:0]       nxt_slot_cnt;
	logic              do_write;
	logic              wr_ok;
	logic              locked;
	logic [7:0]        wr_idx;
	logic [7:0]        rd_idx;
	logic              slow_mode;
	logic              slot_tick;
	logic [31:0]       slot_last;
	logic [7:0]        step_w;
	logic [2:0][7:0]   duty_w;
	logic [2:0][7:0]   ramp_w;
	logic [2:0]        pwm_w;

	// aligned word inside the decoded window and one of the mapped indices
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx     = a[9:2];
		reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0)
			&& (idx == IDX_CFG6 || idx == IDX_CFG1 || idx == IDX_FAN_CFG
			|| idx == IDX_ACOU2 || idx == IDX_DUTY_STAT);
	endfunction : reg_hit

	assign s_axi_awready = clk_en && !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = clk_en && !w_got_ff && !bvalid_ff;
	assign s_axi_arready = clk_en && !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign do_write      = aw_got_ff && w_got_ff && !bvalid_ff;
	assign wr_idx        = awaddr_ff[9:2];
	assign rd_idx        = s_axi_araddr[9:2];
	assign wr_ok         = do_write && wstrb0_ff && reg_hit(awaddr_ff);
	assign locked        = cfg1_ff[CFG1_LOCK_BIT];

	always_comb begin
		nxt_awaddr = awaddr_ff;
		nxt_aw_got = aw_got_ff;
		nxt_wdata  = wdata_ff;
		nxt_wstrb0 = wstrb0_ff;
		nxt_w_got  = w_got_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp  = bresp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_got = 1'b1;
			nxt_awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_got  = 1'b1;
			nxt_wdata  = s_axi_wdata[7:0];
			nxt_wstrb0 = s_axi_wstrb[0];
		end
		if (do_write) begin
			nxt_aw_got = 1'b0;
			nxt_w_got  = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp  = reg_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (rd_idx)
				IDX_CFG6:      nxt_rdata = {24'h000000, cfg6_ff};
				IDX_CFG1:      nxt_rdata = {24'h000000, cfg1_ff};
				IDX_FAN_CFG:   nxt_rdata = {24'h000000, fan_cfg_ff};
				IDX_ACOU2:     nxt_rdata = {24'h000000, acou2_ff};
				IDX_DUTY_STAT: nxt_rdata = {8'h00, duty_w[2], duty_w[1], duty_w[0]};
				default:       nxt_rdata = 32'h00000000;
			endcase
			if (!reg_hit(s_axi_araddr)) begin
				nxt_rdata = 32'h00000000;
			end
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_comb begin
		nxt_cfg6    = cfg6_ff;
		nxt_cfg1    = cfg1_ff;
		nxt_fan_cfg = fan_cfg_ff;
		nxt_acou2   = acou2_ff;
		if (wr_ok && wr_idx == IDX_CFG6) begin
			nxt_cfg6 = wdata_ff;
		end
		if (wr_ok && !locked) begin
			case (wr_idx)
				IDX_CFG1:    nxt_cfg1    = wdata_ff;
				IDX_FAN_CFG: nxt_fan_cfg = wdata_ff;
				IDX_ACOU2:   nxt_acou2   = wdata_ff;
				default:     nxt_cfg1    = cfg1_ff;
			endcase
		end
		// speed inputs c and d always follow fan c; b only with sync set
		nxt_sync = {2'b11, fan_cfg_ff[FC_SYNC_BIT], 1'b0};
	end

	assign slow_mode = cfg6_ff[CFG6_SLOW_BIT];
	assign slot_last = slow_mode ? 32'(SLOW_CYC - 1) : 32'(FAST_CYC - 1);
	assign slot_tick = (slot_cnt_ff >= slot_last);
	assign step_w    = rate_step(acou2_ff[ACOU_RATE_LSB +: 3]);

	always_comb begin
		nxt_slot_cnt = slot_tick ? 32'h00000000 : 32'(slot_cnt_ff + 32'h00000001);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			awaddr_ff   <= '0;
			aw_got_ff   <= 1'b0;
			wdata_ff    <= 8'h00;
			wstrb0_ff   <= 1'b0;
			w_got_ff    <= 1'b0;
			bvalid_ff   <= 1'b0;
			bresp_ff    <= RESP_OKAY;
			rvalid_ff   <= 1'b0;
			rdata_ff    <= 32'h00000000;
			rresp_ff    <= RESP_OKAY;
			cfg6_ff     <= CFG6_RST;
			cfg1_ff     <= CFG1_RST;
			fan_cfg_ff  <= FAN_CFG_RST;
			acou2_ff    <= ACOU2_RST;
			sync_ff     <= 4'h0;
			slot_cnt_ff <= 32'h00000000;
		end else if (clk_en) begin
			awaddr_ff   <= nxt_awaddr;
			aw_got_ff   <= nxt_aw_got;
			wdata_ff    <= nxt_wdata;
			wstrb0_ff   <= nxt_wstrb0;
			w_got_ff    <= nxt_w_got;
			bvalid_ff   <= nxt_bvalid;
			bresp_ff    <= nxt_bresp;
			rvalid_ff   <= nxt_rvalid;
			rdata_ff    <= nxt_rdata;
			rresp_ff    <= nxt_rresp;
			cfg6_ff     <= nxt_cfg6;
			cfg1_ff     <= nxt_cfg1;
			fan_cfg_ff  <= nxt_fan_cfg;
			acou2_ff    <= nxt_acou2;
			sync_ff     <= nxt_sync;
			slot_cnt_ff <= nxt_slot_cnt;
		end
	end

	assign speed_sync_enable = sync_ff;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_fan
			ramp_if ch ();
			assign ch.slot_tick = slot_tick;
			assign ch.step      = step_w;
			// local always ramps; remote one only with smoothing on
			assign ch.ramp_en   = (control_source[gi] == SRC_LOCAL)
				|| (control_source[gi] == SRC_REMOTE1 && fan_cfg_ff[FC_SMOOTH_BIT]);
			assign ch.target    = target_duty[gi];
			assign ch.auto_mode = auto_mode[gi];
			assign ch.below     = below_threshold[gi];
			assign ch.min_duty  = min_duty[gi];
			assign ch.min_sel   = fan_cfg_ff[FC_MINSEL_LSB + gi];
			assign duty_w[gi]   = ch.duty;
			assign ramp_w[gi]   = ch.ramp;
			assign pwm_w[gi]    = ch.pwm;

			fan_channel u_chan (
				.core_clk (core_clk),
				.reset    (reset),
				.clk_en   (clk_en),
				.ch       (ch.chan)
			);

			a_remote_smooth_hold: assert property (@(posedge core_clk) disable iff (reset)
				clk_en && control_source[gi] == SRC_REMOTE1 && fan_cfg_ff[FC_SMOOTH_BIT]
				&& !slot_tick |=> ramp_w[gi] == $past(ramp_w[gi]))
				else $error("remote one change not smoothed");
		end
	endgenerate

	assign fan_drive_a = pwm_w[0];
	assign fan_drive_b = pwm_w[1];
	assign fan_drive_c = pwm_w[2];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_locked_write;
		clk_en && locked && do_write;
	endsequence

	a_lock_blocks_write: assert property (
		s_locked_write |=> $stable(fan_cfg_ff) && $stable(acou2_ff) && $stable(cfg1_ff))
		else $error("write changed a locked register");
	a_acou_reset_zero: assert property (
		$fell(reset) |-> acou2_ff == 8'h00)
		else $error("acoustic register two not zero after reset");
	a_tach_sync_map: assert property (
		clk_en |=> speed_sync_enable == {2'b11, $past(fan_cfg_ff[FC_SYNC_BIT]), 1'b0})
		else $error("speed sync mapping wrong");
	a_slot_fast_len: assert property (
		clk_en && !slow_mode && slot_cnt_ff < 32'(FAST_CYC - 1) |-> !slot_tick)
		else $error("fast slot ended early");
	a_slot_slow_len: assert property (
		clk_en && slow_mode && slot_cnt_ff == 32'(SLOW_CYC - 1) |-> slot_tick
			##1 slot_cnt_ff == 32'h00000000)
		else $error("slow slot length wrong");
	a_rate_code_ends: assert property (
		(acou2_ff[ACOU_RATE_LSB +: 3] == 3'h0 |-> step_w == 8'h01)
		and (acou2_ff[ACOU_RATE_LSB +: 3] == 3'h7 |-> step_w == 8'h30))
		else $error("rate code step wrong");
	a_fan_a_floor: assert property (
		clk_en && auto_mode[0] && below_threshold[0]
		|=> duty_w[0] == ($past(fan_cfg_ff[FC_MINSEL_LSB]) ? $past(min_duty[0]) : 8'h00))
		else $error("fan a below-threshold duty wrong");
	a_fan_b_floor: assert property (
		clk_en && auto_mode[1] && below_threshold[1]
		|=> duty_w[1] == ($past(fan_cfg_ff[FC_MINSEL_LSB + 1]) ? $past(min_duty[1]) : 8'h00))
		else $error("fan b below-threshold duty wrong");
	a_fan_c_floor: assert property (
		clk_en && auto_mode[2] && below_threshold[2]
		|=> duty_w[2] == ($past(fan_cfg_ff[FC_MINSEL_LSB + 2]) ? $past(min_duty[2]) : 8'h00))
		else $error("fan c below-threshold duty wrong");
endmodule : fan_acoustic_control_config

// ### testbench/fan_tach_model.sv
// fan model: measures the on time of each pwm drive over one 255-clock period
`timescale 1ns/100ps
module fan_tach_model (
	input  wire logic            core_clk,
	input  wire logic [2:0]      drive,
	output logic      [2:0][7:0] duty_seen
);
	logic [7:0]      win_cnt;
	logic [2:0][7:0] high_cnt;
	initial begin
		win_cnt = 8'h00;
		high_cnt = '0;
		duty_seen = '0;
	end
	always @(posedge core_clk) begin
		for (int i = 0; i < 3; i++) begin
			if (win_cnt == 8'hFE) begin
				duty_seen[i] <= high_cnt[i] + 8'(drive[i]);
				high_cnt[i] <= 8'h00;
			end else
				high_cnt[i] <= high_cnt[i] + 8'(drive[i]);
		end
		win_cnt <= (win_cnt == 8'hFE) ? 8'h00 : win_cnt + 8'h01;
	end
endmodule : fan_tach_model

// ### testbench/tb.sv
// self-checking bench of the fan acoustic configuration block
`timescale 1ns/100ps
module tb
	import fan_pkg::*;
;
	localparam int          FAST = 8;
	localparam int          SLOW = 12;
	localparam int          STEPS [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
	localparam logic [11:0] A_CFG6 = 12'({IDX_CFG6, 2'h0});
	localparam logic [11:0] A_CFG1 = 12'({IDX_CFG1, 2'h0});
	localparam logic [11:0] A_FAN  = 12'({IDX_FAN_CFG, 2'h0});
	localparam logic [11:0] A_ACOU = 12'({IDX_ACOU2, 2'h0});
	localparam logic [11:0] A_STAT = 12'({IDX_DUTY_STAT, 2'h0});
	logic            core_clk, reset, clk_en;
	logic [11:0]     awaddr, araddr;
	logic            awvalid, awready, wvalid, wready, bvalid, bready;
	logic            arvalid, arready, rvalid, rready;
	logic [31:0]     wdata, rdata, d, rnd;
	logic [3:0]      wstrb, sync_en;
	logic [1:0]      bresp, rresp, r;
	logic [2:0]      auto_m, below, drv;
	logic [2:0][7:0] tgt, min_d, seen;
	logic [2:0][1:0] src;
	int              seed, cyc, n_fail, total_checks;

	fan_acoustic_control_config #(.ADDR_W(12), .FAST_CYC(FAST), .SLOW_CYC(SLOW))
		fan_acoustic_control_config_inst (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .auto_mode(auto_m),
		.below_threshold(below), .target_duty(tgt), .min_duty(min_d),
		.control_source(src), .fan_drive_a(drv[0]), .fan_drive_b(drv[1]),
		.fan_drive_c(drv[2]), .speed_sync_enable(sync_en));
	fan_tach_model fan_tach_model_inst (.core_clk(core_clk), .drive(drv), .duty_seen(seen));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc++;

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	function automatic logic [7:0] exp_floor(input logic sel, input logic [7:0] mn);
		return sel ? mn : 8'h00;
	endfunction : exp_floor

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
		logic aw_t, w_t, b_t;
		int   n;
		n = 0;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge core_clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bready && bvalid;
			if (b_t) r = bresp;
			@(posedge core_clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			n++;
		end while (!b_t && n < 200);
		bready <= 1'b0;
		if (!b_t) n_fail++;
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a);
		logic ar_t, r_t;
		int   n;
		n = 0;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge core_clk);
			ar_t = arvalid && arready;
			r_t = rready && rvalid;
			d = rdata;
			r = rresp;
			@(posedge core_clk);
			if (ar_t) arvalid <= 1'b0;
			n++;
		end while (!r_t && n < 200);
		rready <= 1'b0;
		if (!r_t) n_fail++;
	endtask : axi_rd

	task automatic ramp_run(input logic slow, input int code);
		logic [7:0] st, tg;
		int         t0, n, sc;
		st = 8'(STEPS[code]);
		tg = st * 8'h04;
		sc = slow ? SLOW : FAST;
		tgt <= '0;
		repeat (6 * SLOW * 4) @(posedge core_clk);
		axi_wr(A_CFG6, {24'h0, slow, 7'h0});
		axi_wr(A_ACOU, 32'(code));
		tgt <= {3{tg}};
		t0 = cyc;
		n = 0;
		axi_rd(A_STAT);
		check("ramp_no_jump", 32'(d[7:0] < tg), 32'h1);
		while (d[7:0] !== tg && n < 100) begin
			check("ramp_step", 32'(d[7:0] % st), 32'h0);
			axi_rd(A_STAT);
			n++;
		end
		check("ramp_end", 32'(d[7:0]), 32'(tg));
		n = cyc - t0;
		check("ramp_time", 32'(n >= 3 * sc && n <= 4 * sc + 12), 32'h1);
	endtask : ramp_run

	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report

	initial begin
		#(8 * 60000);
		n_fail++;
		final_report();
	end

	initial begin
		seed = 71827;
		{reset, clk_en, awvalid, wvalid, bready, arvalid, rready} = 7'b1100000;
		{awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hF};
		{auto_m, below, tgt, min_d, src} = '0;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		check("sync_reset", 32'(sync_en), 32'h0000000C);
		axi_rd(A_ACOU);
		check("acou2_reset", d, 32'h00000000);
		axi_rd(12'h004);
		check("unmapped_resp", 32'(r), 32'(RESP_SLVERR));
		for (int i = 0; i < 6; i++) begin
			rnd = $random(seed);
			axi_wr(A_FAN, {24'h0, rnd[7:0]});
			axi_rd(A_FAN);
			check("fan_cfg_rw", d, {24'h0, rnd[7:0]});
			repeat (3) @(posedge core_clk);
			check("sync_bit", 32'(sync_en), {28'h0, 2'b11, rnd[4], 1'b0});
		end
		auto_m <= 3'h7;
		below <= 3'h7;
		src <= {3{2'h2}};
		for (int s = 0; s < 8; s++) begin
			min_d <= {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
			tgt <= {8'($random(seed)), 8'($random(seed)), 8'($random(seed))};
			axi_wr(A_FAN, {24'h0, 3'(s), 5'h0});
			repeat (600) @(posedge core_clk);
			axi_rd(A_STAT);
			check("floor_a", 32'(d[7:0]), 32'(exp_floor(s[0], min_d[0])));
			check("floor_b", 32'(d[15:8]), 32'(exp_floor(s[1], min_d[1])));
			check("floor_c", 32'(d[23:16]), 32'(exp_floor(s[2], min_d[2])));
			check("pwm_a", 32'(seen[0]), 32'(exp_floor(s[0], min_d[0])));
			check("pwm_b", 32'(seen[1]), 32'(exp_floor(s[1], min_d[1])));
			check("pwm_c", 32'(seen[2]), 32'(exp_floor(s[2], min_d[2])));
		end
		auto_m <= 3'h0;
		repeat (4) @(posedge core_clk);
		axi_rd(A_STAT);
		check("manual_no_floor", 32'(d[23:0]), 32'(tgt));
		// settle the ramp at zero while the channels still jump
		tgt <= '0;
		axi_wr(A_FAN, 32'h0);
		auto_m <= 3'h7;
		below <= 3'h0;
		src <= '0;
		for (int sl = 0; sl < 2; sl++)
			for (int c = 0; c < 8; c++)
				ramp_run(sl[0], c);
		axi_wr(A_ACOU, 32'h0);
		src <= {3{2'h1}};
		tgt <= '0;
		repeat (8) @(posedge core_clk);
		tgt <= {3{8'hC8}};
		repeat (8) @(posedge core_clk);
		axi_rd(A_STAT);
		check("remote_jump", 32'(d[7:0]), 32'h000000C8);
		tgt <= '0;
		repeat (8) @(posedge core_clk);
		axi_wr(A_FAN, 32'h00000008);
		tgt <= {3{8'hC8}};
		repeat (8) @(posedge core_clk);
		axi_rd(A_STAT);
		check("remote_smooth", 32'(d[7:0] < 8'hC8), 32'h1);
		axi_wr(A_FAN, 32'h00000018);
		axi_wr(A_ACOU, 32'h00000005);
		axi_wr(A_CFG1, 32'h00000002);
		axi_wr(A_FAN, 32'h000000E7);
		check("locked_resp", 32'(r), 32'(RESP_OKAY));
		axi_wr(A_ACOU, 32'h00000002);
		axi_rd(A_FAN);
		check("locked_fan", d, 32'h00000018);
		axi_rd(A_ACOU);
		check("locked_acou", d, 32'h00000005);
		reset <= 1'b1;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		axi_rd(A_ACOU);
		check("acou2_rereset", d, 32'h00000000);
		axi_wr(A_ACOU, 32'h00000003);
		axi_rd(A_ACOU);
		check("unlocked_acou", d, 32'h00000003);
		// byte lane zero off: the write is answered but changes nothing
		wstrb <= 4'hE;
		axi_wr(A_ACOU, 32'h00000006);
		wstrb <= 4'hF;
		axi_rd(A_ACOU);
		check("strb_ignored", d, 32'h00000003);
		// clock enable low: the bus refuses every request
		clk_en <= 1'b0;
		repeat (3) @(posedge core_clk);
		check("frozen_ready", 32'({awready, wready, arready}), 32'h0);
		clk_en <= 1'b1;
		repeat (2) @(posedge core_clk);
		check("live_ready", 32'({awready, wready, arready}), 32'h7);
		final_report();
	end
endmodule : tb
